// ==== core/rsam_defs.svh ====
`ifndef RSAM_DEFS_SVH
`define RSAM_DEFS_SVH

`define RSAM_ADDR_CTRL 8'h00
`define RSAM_ADDR_STAT 8'h04
`define RSAM_ADDR_DATA 8'h08

`define RSAM_CTRL_WG 0
`define RSAM_CTRL_RG 1
`define RSAM_CTRL_MC 2
`define RSAM_STAT_OVR 5
`define RSAM_STAT_BAD 6

`define RSAM_FIFO_WIDTH 8
`define RSAM_FIFO_DEPTH 32

`define RSAM_MARK_CODE 8'h04
`define RSAM_SYNC_CODE 8'h90
`define RSAM_ALIGN_CODE 8'h40
`define RSAM_ALIGN_NIB 4'h4
`define RSAM_SYNC_LM1 3'h5
`define RSAM_ALIGN_LM1 3'h3
`define RSAM_MARK_LM1 3'h7
`define RSAM_SKIP_MARK 4'hF
`define RSAM_ALIGN_COUNT 4'h8
`define RSAM_PRE_COUNT 3'h5
`define RSAM_BYTE_BITS 4'h8
`define RSAM_LOOKAHEAD 4'h4
`define RSAM_ONES 12'hFFF

`endif

// ==== core/rsam_pkg.sv ====
package rsam_pkg;

  typedef enum logic [2:0] {
    E_IDLE = 3'h0,
    E_SYNC = 3'h1,
    E_ALIGN = 3'h3,
    E_MARK1 = 3'h2,
    E_MARK2 = 3'h6,
    E_DATA = 3'h7
  } rsam_estate_t;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic cs3;
    logic ds1;
    logic ds2;
    logic wg;
    logic rg;
    logic mc;
    logic mc_prev;
    rsam_estate_t estate;
    logic [2:0] eskip;
    logic [7:0] ecode;
    logic code_out;
    logic [11:0] dacc;
    logic [3:0] dcnt;
    logic [3:0] acnt;
    logic [7:0] cw;
    logic [3:0] dskip;
    logic [2:0] pcnt;
    logic done;
    logic latch;
    logic found;
    logic dclk;
    logic [11:0] oacc;
    logic [3:0] ocnt;
    logic overrun;
    logic bad;
    logic [31:0] prdata;
  } rsam_state_t;

endpackage

// ==== core/rsam_ctrl.sv ====
// How it works
// [RULE1] Address mark is code word 00000100
// [RULE2] Data clock rises at each pattern start
// [RULE3] Write exactly eight 0100 alignment groups
// [RULE4] Sync field feeds zeros, emits 100100
// [RULE5] Mark control sets latch, forcing ones
// [RULE6] Eighth alignment group sets done, mark follows
// [RULE7] Two mark copies; second raises found
// [RULE8] Controller supplies data once found rises
// [RULE9] Read needs five alignment groups first
// [RULE10] Read gate with mark control clears flags
// [RULE11] Fifth consecutive 0100 sets done flag
// [RULE12] Other pattern clears done and count
// [RULE13] Read mark found sets latch, opens data
// [RULE14] Read latch holds while read gate high
// [RULE15] Bad pair: state zero, output zero
// [RULE16] One data bit per two code bits
// [RULE17] Data clock is code clock halved
// [RULE18] Count in 4-bit groups, clear on gate fall
`include "rsam_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module rsam_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rsam_fifo_state_t;

  rsam_fifo_state_t r_ff;
  rsam_fifo_state_t nxt_r;
  logic push;
  logic pop;

  always_comb begin
    nxt_r = r_ff;
    in_ready_out = r_ff.cnt != FULL;
    out_valid_out = r_ff.cnt != '0;
    out_data_out = r_ff.mem[r_ff.rp];
    push = in_valid_in & in_ready_out;
    pop = out_valid_out & out_ready_in;
    if (push) begin
      nxt_r.mem[r_ff.wp] = in_data_in;
      nxt_r.wp = r_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_r.rp = r_ff.rp + 1'b1;
    end
    if (push & ~pop) begin
      nxt_r.cnt = r_ff.cnt + 1'b1;
    end else if (pop & ~push) begin
      nxt_r.cnt = r_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end
endmodule

module rsam_ctrl
  import rsam_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic CODE_CLK_IN,
  input wire logic CODE_DATA_IN,
  output logic CODE_OUT,
  output logic CODE_OE_OUT,
  output logic DATA_CLK_OUT,
  output logic MARK_FOUND_OUT,
  output logic MARK_LATCH_OUT,
  output logic PREAMBLE_DONE_OUT
);
  rsam_state_t r_ff;
  rsam_state_t nxt_r;
  logic f_in_valid;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_in_data;
  logic [7:0] f_out_data;
  logic ce;
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_data;
  logic mc_rise;
  logic dec_bad;
  logic enc_pop;
  logic [15:0] eg;
  logic [11:0] dg;
  logic [7:0] sh;
  logic [11:0] ob;
  logic [7:0] g;
  logic [2:0] lm;
  logic ld;

  // Table groups: {code left aligned, length-1, data bits used}
  function automatic logic [15:0] enc_grp(input logic [3:0] w);
    casez (w)
      4'b10??: enc_grp = {8'h40, 4'h3, 4'h2};
      4'b11??: enc_grp = {8'h80, 4'h3, 4'h2};
      4'b000?: enc_grp = {8'h10, 4'h5, 4'h3};
      4'b010?: enc_grp = {8'h90, 4'h5, 4'h3};
      4'b011?: enc_grp = {8'h20, 4'h5, 4'h3};
      4'b0010: enc_grp = {8'h24, 4'h7, 4'h4};
      default: enc_grp = {8'h08, 4'h7, 4'h4};
    endcase
  endfunction

  // Returns {bad, data bits right aligned, bit count, length-1}
  function automatic logic [11:0] dec_grp(input logic [7:0] c);
    casez (c)
      8'b0100????: dec_grp = {1'b0, 4'h2, 3'h2, 4'h3};
      8'b1000????: dec_grp = {1'b0, 4'h3, 3'h2, 4'h3};
      8'b000100??: dec_grp = {1'b0, 4'h0, 3'h3, 4'h5};
      8'b100100??: dec_grp = {1'b0, 4'h2, 3'h3, 4'h5};
      8'b001000??: dec_grp = {1'b0, 4'h3, 3'h3, 4'h5};
      8'b00100100: dec_grp = {1'b0, 4'h2, 3'h4, 4'h7};
      8'b00001000: dec_grp = {1'b0, 4'h3, 3'h4, 4'h7};
      default: dec_grp = {1'b1, 4'h0, 3'h1, 4'h1};
    endcase
  endfunction

  rsam_fifo #(
    .WIDTH(`RSAM_FIFO_WIDTH),
    .DEPTH(`RSAM_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLK_SYS_IN),
    .reset_in(RESET_IN),
    .in_valid_in(f_in_valid),
    .in_data_in(f_in_data),
    .in_ready_out(f_in_ready),
    .out_valid_out(f_out_valid),
    .out_data_out(f_out_data),
    .out_ready_in(f_out_ready)
  );

  always_comb begin
    nxt_r = r_ff;
    g = `RSAM_SYNC_CODE;
    lm = `RSAM_SYNC_LM1;
    ld = 1'b0;
    enc_pop = 1'b0;
    dec_bad = 1'b0;
    // The first flop of each synchroniser is read only by the second flop
    nxt_r.cs1 = CODE_CLK_IN;
    nxt_r.cs2 = r_ff.cs1;
    nxt_r.cs3 = r_ff.cs2;
    nxt_r.ds1 = CODE_DATA_IN;
    nxt_r.ds2 = r_ff.ds1;
    ce = r_ff.cs2 & ~r_ff.cs3;
    sh = {r_ff.cw[6:0], r_ff.ds2};
    eg = enc_grp(r_ff.dacc[11:8]);
    dg = dec_grp(sh);
    ob = r_ff.oacc >> (r_ff.ocnt - `RSAM_BYTE_BITS);
    mc_rise = r_ff.mc & ~r_ff.mc_prev;
    nxt_r.mc_prev = r_ff.mc;

    hit_ctrl = PADDR_IN == `RSAM_ADDR_CTRL;
    hit_stat = PADDR_IN == `RSAM_ADDR_STAT;
    hit_data = PADDR_IN == `RSAM_ADDR_DATA;
    // Writes to a full buffer wait rather than drop bytes while the read gate is low
    PREADY_OUT = ~(PSEL_IN & PENABLE_IN & PWRITE_IN & hit_data &
                   ~r_ff.rg & ~f_in_ready);
    acc = PSEL_IN & PENABLE_IN & PREADY_OUT;
    PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~(hit_ctrl | hit_stat | hit_data);
    PRDATA_OUT = r_ff.prdata;

    if (PSEL_IN & ~PENABLE_IN) begin
      if (hit_ctrl) begin
        nxt_r.prdata = {29'h0, r_ff.mc, r_ff.rg, r_ff.wg};
      end else if (hit_stat) begin
        nxt_r.prdata = {21'h0, r_ff.pcnt, 1'b0, r_ff.bad, r_ff.overrun,
                        ~f_in_ready, ~f_out_valid, r_ff.latch, r_ff.done,
                        r_ff.found};
      end else if (hit_data) begin
        nxt_r.prdata = {24'h0, f_out_data};
      end else begin
        nxt_r.prdata = 32'h0;
      end
    end
    if (acc & PWRITE_IN & hit_ctrl) begin
      nxt_r.wg = PWDATA_IN[`RSAM_CTRL_WG];
      nxt_r.rg = PWDATA_IN[`RSAM_CTRL_RG];
      nxt_r.mc = PWDATA_IN[`RSAM_CTRL_MC];
    end
    // Clear first so a same-cycle event still sets the flag
    if (acc & PWRITE_IN & hit_stat) begin
      nxt_r.overrun = r_ff.overrun & ~PWDATA_IN[`RSAM_STAT_OVR];
      nxt_r.bad = r_ff.bad & ~PWDATA_IN[`RSAM_STAT_BAD];
    end

    if (~r_ff.rg) begin
      nxt_r.pcnt = 3'h0; // [RULE18]
    end

    if (~r_ff.wg & ~r_ff.rg) begin
      nxt_r.estate = E_IDLE;
      nxt_r.done = 1'b0;
      nxt_r.latch = 1'b0;
      nxt_r.found = 1'b0;
      nxt_r.eskip = 3'h0;
      nxt_r.code_out = 1'b0;
      nxt_r.dacc = 12'h000;
      nxt_r.dcnt = 4'h0;
      nxt_r.acnt = 4'h0;
      nxt_r.dskip = 4'h0;
      nxt_r.ocnt = 4'h0;
    end else if (r_ff.rg) begin
      nxt_r.estate = E_IDLE;
      // Decoder cannot stall the disk, so a full buffer drops the byte
      if (r_ff.ocnt >= `RSAM_BYTE_BITS) begin
        nxt_r.ocnt = r_ff.ocnt - `RSAM_BYTE_BITS;
        if (~f_in_ready) begin
          nxt_r.overrun = 1'b1;
        end
      end
      if (ce) begin
        nxt_r.cw = sh;
        nxt_r.dclk = ~r_ff.dclk; // [RULE17]
        if (r_ff.dskip != 4'h0) begin
          nxt_r.dskip = r_ff.dskip - 4'h1; // [RULE18]
        end else if (~r_ff.latch) begin
          if (r_ff.done & (sh == `RSAM_MARK_CODE)) begin // [RULE1] [RULE9]
            nxt_r.found = 1'b1; // [RULE13]
            nxt_r.latch = 1'b1; // [RULE13]
            nxt_r.dskip = `RSAM_SKIP_MARK;
          end else if (sh[7:4] == `RSAM_ALIGN_NIB) begin
            if (r_ff.pcnt != `RSAM_PRE_COUNT) begin
              nxt_r.pcnt = r_ff.pcnt + 3'h1;
            end
            if (r_ff.pcnt >= `RSAM_PRE_COUNT - 3'h1) begin
              nxt_r.done = 1'b1; // [RULE11]
            end
            nxt_r.dskip = {1'b0, `RSAM_ALIGN_LM1}; // [RULE18]
            nxt_r.dclk = 1'b1; // [RULE2]
          end else begin
            // Sliding one bit at a time hunts for group alignment
            nxt_r.pcnt = 3'h0; // [RULE12]
            nxt_r.done = 1'b0; // [RULE12]
          end
        end else begin
          nxt_r.dskip = dg[3:0]; // [RULE16]
          nxt_r.oacc = (r_ff.oacc << dg[6:4]) | {8'h00, dg[10:7]};
          nxt_r.ocnt = nxt_r.ocnt + {1'b0, dg[6:4]};
          if (dg[11]) begin
            dec_bad = 1'b1; // [RULE15]
            nxt_r.bad = 1'b1;
          end
        end
      end
      if (mc_rise) begin
        nxt_r.done = 1'b0; // [RULE10]
        nxt_r.latch = 1'b0; // [RULE10]
        nxt_r.found = 1'b0;
        nxt_r.pcnt = 3'h0;
      end
    end else begin
      if (r_ff.estate == E_IDLE) begin
        nxt_r.estate = E_SYNC;
      end
      if (mc_rise & (r_ff.estate == E_SYNC)) begin
        nxt_r.latch = 1'b1; // [RULE5]
        nxt_r.dacc = `RSAM_ONES; // [RULE5]
      end
      if (ce) begin
        nxt_r.dclk = ~r_ff.dclk; // [RULE17]
        if (r_ff.eskip == 3'h0) begin
          ld = 1'b1;
          case (r_ff.estate)
            E_IDLE, E_SYNC: begin
              if (r_ff.latch) begin
                g = `RSAM_ALIGN_CODE; // [RULE5]
                lm = `RSAM_ALIGN_LM1;
                nxt_r.acnt = 4'h1;
                nxt_r.estate = E_ALIGN;
              end else begin
                g = `RSAM_SYNC_CODE; // [RULE4]
                lm = `RSAM_SYNC_LM1;
              end
            end
            E_ALIGN: begin
              if (r_ff.acnt == `RSAM_ALIGN_COUNT) begin // [RULE3]
                nxt_r.done = 1'b1; // [RULE6]
                g = `RSAM_MARK_CODE; // [RULE6]
                lm = `RSAM_MARK_LM1;
                nxt_r.estate = E_MARK1;
                nxt_r.dacc = 12'h000;
                nxt_r.dcnt = 4'h0;
              end else begin
                g = `RSAM_ALIGN_CODE;
                lm = `RSAM_ALIGN_LM1;
                nxt_r.acnt = r_ff.acnt + 4'h1;
              end
            end
            E_MARK1: begin
              g = `RSAM_MARK_CODE; // [RULE7]
              lm = `RSAM_MARK_LM1;
              nxt_r.found = 1'b1; // [RULE7]
              nxt_r.latch = 1'b0; // [RULE7]
              nxt_r.estate = E_MARK2;
            end
            default: begin
              // Buffer underrun pads with zero data
              g = eg[15:8];
              lm = eg[6:4];
              nxt_r.estate = E_DATA;
              nxt_r.dacc = r_ff.dacc << eg[3:0];
              if (r_ff.dcnt > eg[3:0]) begin
                nxt_r.dcnt = r_ff.dcnt - eg[3:0];
              end else begin
                nxt_r.dcnt = 4'h0;
              end
            end
          endcase
        end
        if (ld) begin
          nxt_r.code_out = g[7];
          nxt_r.ecode = {g[6:0], 1'b0};
          nxt_r.eskip = lm;
        end else begin
          nxt_r.code_out = r_ff.ecode[7];
          nxt_r.ecode = {r_ff.ecode[6:0], 1'b0};
          nxt_r.eskip = r_ff.eskip - 3'h1;
        end
      end else if (((r_ff.estate == E_MARK2) | (r_ff.estate == E_DATA)) &
                   (r_ff.dcnt <= `RSAM_LOOKAHEAD) & f_out_valid) begin
        enc_pop = 1'b1; // [RULE8]
        nxt_r.dacc = r_ff.dacc | ({f_out_data, 4'h0} >> r_ff.dcnt);
        nxt_r.dcnt = r_ff.dcnt + `RSAM_BYTE_BITS;
      end
    end

    f_in_valid = r_ff.rg ? (r_ff.ocnt >= `RSAM_BYTE_BITS) :
                 (acc & PWRITE_IN & hit_data);
    f_in_data = r_ff.rg ? ob[7:0] : PWDATA_IN[7:0];
    f_out_ready = r_ff.rg ? (acc & ~PWRITE_IN & hit_data) : enc_pop;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign CODE_OUT = r_ff.code_out;
  assign CODE_OE_OUT = r_ff.wg & ~r_ff.rg;
  assign DATA_CLK_OUT = r_ff.dclk;
  assign MARK_FOUND_OUT = r_ff.found;
  assign MARK_LATCH_OUT = r_ff.latch;
  assign PREAMBLE_DONE_OUT = r_ff.done;

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RESET_IN);

  mark_word_a: assert property ( // [RULE1]
    (r_ff.rg && $rose(r_ff.found)) |-> r_ff.cw == `RSAM_MARK_CODE
  ) else $error("read mark found on a non-mark word");

  clk_phase_a: assert property ( // [RULE2]
    (r_ff.rg && r_ff.pcnt > $past(r_ff.pcnt)) |-> r_ff.dclk
  ) else $error("data clock low at alignment group start");

  align_count_a: assert property ( // [RULE3]
    (r_ff.wg && !r_ff.rg && $rose(r_ff.done))
      |-> r_ff.acnt == `RSAM_ALIGN_COUNT
  ) else $error("done raised after wrong alignment count");

  sync_zero_a: assert property ( // [RULE4]
    (r_ff.estate == E_SYNC && !r_ff.latch) |-> r_ff.dacc == 12'h000
  ) else $error("sync field fed nonzero data");

  force_ones_a: assert property ( // [RULE5]
    ($rose(r_ff.latch) && r_ff.wg && !r_ff.rg) |-> r_ff.dacc == `RSAM_ONES
  ) else $error("mark latch set without ones forced");

  mark_after_done_a: assert property ( // [RULE6]
    (r_ff.estate == E_MARK1) |-> r_ff.done
  ) else $error("mark written before done");

  second_copy_a: assert property ( // [RULE7]
    (!r_ff.rg && $rose(r_ff.found))
      |-> (r_ff.estate == E_MARK2 && !r_ff.latch)
  ) else $error("found not at second mark copy");

  pre_five_a: assert property ( // [RULE11] [RULE9]
    (r_ff.rg && $rose(r_ff.done)) |-> r_ff.pcnt == `RSAM_PRE_COUNT
  ) else $error("done raised on wrong pattern count");

  arm_clear_a: assert property ( // [RULE10]
    (r_ff.rg && mc_rise) |=> (!r_ff.done && !r_ff.latch)
  ) else $error("arming did not clear done and latch");

  pre_reset_a: assert property ( // [RULE12]
    (r_ff.rg && !r_ff.latch && $fell(r_ff.done)) |-> r_ff.pcnt == 3'h0
  ) else $error("done cleared without count restart");

  rd_latch_a: assert property ( // [RULE13]
    (r_ff.rg && $rose(r_ff.found)) |-> r_ff.latch ##1 r_ff.dskip != 4'h0
  ) else $error("mark found did not open the data path");

  latch_hold_a: assert property ( // [RULE14]
    (r_ff.rg && r_ff.latch && !mc_rise) |=> (r_ff.latch || !r_ff.rg)
  ) else $error("read latch dropped while read gate high");

  bad_pair_a: assert property ( // [RULE15]
    (r_ff.rg && dec_bad) |=> (r_ff.dskip == 4'h1 && r_ff.bad)
  ) else $error("bad code pair not resynchronised");

  half_rate_a: assert property ( // [RULE17]
    (ce && r_ff.wg && !r_ff.rg) |=> r_ff.dclk != $past(r_ff.dclk)
  ) else $error("data clock not toggled on code edge");

  gate_fall_a: assert property ( // [RULE18]
    $fell(r_ff.rg) |=> r_ff.pcnt == 3'h0
  ) else $error("pattern count kept after read gate fell");

  rd_mark_c: cover property (r_ff.rg && $rose(r_ff.found));
  wr_data_c: cover property (r_ff.estate == E_DATA && enc_pop);
  overrun_c: cover property ($rose(r_ff.overrun));
  bad_pair_c: cover property (r_ff.rg && r_ff.latch && dec_bad);
endmodule

`default_nettype wire

// ==== bench/rsam_far.sv ====
`timescale 1ns/100ps
`default_nettype none

module rsam_far #(
  parameter int HALF = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic code_in,
  input wire logic code_oe_in,
  output logic code_clk_out,
  output logic code_data_out
);
  logic tx_q[$];
  logic rx_q[$];
  logic pend = 1'b0;
  int cnt = 0;

  initial begin
    code_clk_out = 1'b0;
    code_data_out = 1'b0;
  end

  // Clock stands still outside frames; a read frame ends after its last bit
  always @(posedge clk_in) begin
    if (reset_in) begin
      code_clk_out <= 1'b0;
      pend <= 1'b0;
      cnt <= 0;
    end else if (run_in || tx_q.size() != 0 || pend || code_clk_out) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        code_clk_out <= ~code_clk_out;
        if (!code_clk_out) begin
          pend <= 1'b0;
          if (code_oe_in) rx_q.push_back(code_in);
        end
      end
      // New bit mid low phase, so it is settled well before the rise
      if (cnt == 1 && !code_clk_out) begin
        if (tx_q.size() != 0) begin
          code_data_out <= tx_q.pop_front();
          pend <= 1'b1;
        end else begin
          code_data_out <= ~code_data_out;
        end
      end
    end else begin
      cnt <= 0;
      code_data_out <= ~code_data_out;
    end
  end
endmodule

`default_nettype wire

// ==== bench/tb_rll27_sync_address_mark_control.sv ====
`include "rsam_defs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c) while (!(c)) @(negedge clk)

module tb_rll27_sync_address_mark_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic run = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cclk, cdata, code, code_oe, dclk;
  logic found, latch, done;
  int failures = 0;
  int compares = 0;
  int ws, p;
  logic [7:0] bytes[$];
  logic sq[$], pre[$], exp_q[$];

  always #50 clk = ~clk;

  rsam_ctrl i_dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CODE_CLK_IN(cclk), .CODE_DATA_IN(cdata),
    .CODE_OUT(code), .CODE_OE_OUT(code_oe), .DATA_CLK_OUT(dclk),
    .MARK_FOUND_OUT(found), .MARK_LATCH_OUT(latch),
    .PREAMBLE_DONE_OUT(done));

  rsam_far #(.HALF(4)) i_far (.clk_in(clk), .reset_in(rst), .run_in(run),
    .code_in(code), .code_oe_in(code_oe), .code_clk_out(cclk),
    .code_data_out(cdata));

  task automatic end_of_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    ws = -1;
    do begin
      @(posedge clk);
      ws++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic void bits(input logic [7:0] c, input int n, input int r);
    repeat (r) for (int j = n - 1; j >= 0; j--) sq.push_back(c[j]);
  endfunction

  // Table encoder over the byte list, MSB first, then zero padding
  function automatic void encode();
    logic d[$];
    int i;
    foreach (bytes[k]) for (int j = 7; j >= 0; j--) d.push_back(bytes[k][j]);
    repeat (8) d.push_back(1'b0);
    i = 0;
    while (i + 4 <= d.size()) begin
      if (d[i]) begin
        bits(d[i+1] ? 8'h08 : 8'h04, 4, 1);
        i += 2;
      end else if (d[i+1]) begin
        bits(d[i+2] ? 8'h08 : 8'h24, 6, 1);
        i += 3;
      end else if (!d[i+2]) begin
        bits(8'h04, 6, 1);
        i += 3;
      end else begin
        bits(d[i+3] ? 8'h08 : 8'h24, 8, 1);
        i += 4;
      end
    end
  endfunction

  function automatic int diff(input int at, input logic q[$]);
    int n = 0;
    foreach (q[j]) if (at + j >= i_far.rx_q.size() || i_far.rx_q[at+j] !== q[j]) n++;
    return n;
  endfunction

  task automatic play();
    foreach (sq[k]) i_far.tx_q.push_back(sq[k]);
    sq = {};
    @(negedge clk);
    `WAIT(i_far.tx_q.size() == 0 && !i_far.pend && !cclk);
    repeat (10) @(negedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial begin
    void'($urandom(42));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd, 32'h00000008)
    apb(0, 8'h0C, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    bytes = {8'h00, 8'hFF};
    repeat (31) bytes.push_back(8'($urandom()));
    apb(1, `RSAM_ADDR_CTRL, 32'h1);
    run <= 1'b1;
    for (int k = 0; k < 32; k++) apb(1, `RSAM_ADDR_DATA, {24'h0, bytes[k]});
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd[4], 1'b1)
    repeat (200) @(posedge clk);
    apb(1, `RSAM_ADDR_CTRL, 32'h5);
    `WAIT(latch === 1'b1 || found === 1'b1);
    `CHK(latch, 1'b1)
    apb(1, `RSAM_ADDR_DATA, {24'h0, bytes[32]});
    `CHK(ws > 0, 1'b1)
    `WAIT(found === 1'b1);
    `CHK(latch, 1'b0)
    `CHK(done, 1'b1)
    do apb(0, `RSAM_ADDR_STAT, 0); while (rd[3] !== 1'b1);
    repeat (400) @(posedge clk);
    run <= 1'b0;
    apb(1, `RSAM_ADDR_CTRL, 0);
    bits(8'h24, 6, 1);
    bits(8'h04, 4, 8);
    bits(8'h04, 8, 2);
    pre = sq;
    sq = {};
    encode();
    exp_q = sq;
    sq = {};
    p = -1;
    for (int i = 0; i + pre.size() <= i_far.rx_q.size(); i++) if (p < 0 && diff(i, pre) == 0) p = i;
    `CHK(p >= 0, 1'b1)
    `CHK(diff(p + pre.size(), exp_q), 0)
    bytes = {};
    repeat (3) bytes.push_back(8'($urandom()));
    apb(1, `RSAM_ADDR_CTRL, 32'h2);
    bits(8'h04, 4, 4);
    bits(8'h04, 8, 1);
    play();
    `CHK({found, done}, 2'b00)
    bits(8'h08, 4, 1);
    bits(8'h04, 4, 4);
    play();
    `CHK(done, 1'b0)
    // A group is judged once the next four code bits are behind it
    bits(8'h04, 4, 1);
    bits(8'h00, 4, 1);
    play();
    `CHK(done, 1'b1)
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd[10:8], 3'h5)
    bits(8'h04, 4, 1);
    bits(8'h04, 8, 1);
    encode();
    play();
    `CHK({found, latch}, 2'b11)
    for (int k = 0; k < 3; k++) begin
      apb(0, `RSAM_ADDR_DATA, 0);
      `CHK(rd[7:0], bytes[k])
    end
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd[6], 1'b0)
    bits(8'hFF, 8, 1);
    play();
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd[6], 1'b1)
    `CHK(latch, 1'b1)
    apb(1, `RSAM_ADDR_CTRL, 32'h6);
    repeat (2) @(posedge clk);
    `CHK({latch, done}, 2'b00)
    apb(1, `RSAM_ADDR_CTRL, 0);
    apb(0, `RSAM_ADDR_STAT, 0);
    `CHK(rd[10:8], 3'h0)
    end_of_test();
  end
endmodule

`default_nettype wire
